// ===== hw/esc_pkg.sv
// shared constants and types of the two-wire memory client front end
// assumes a 25 MHz core clock; bus pins arrive unsynchronised
package esc_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ     = 25;
  localparam int unsigned WC_TIME_US  = 5000;
  // longest time rounds down; whole microseconds make it exact here
  localparam int unsigned WC_CYCLES   = WC_TIME_US * CLK_MHZ;

  // ------------------------------------------------------------
  // control byte layout and identity
  // ------------------------------------------------------------
  localparam int unsigned TYPE_MSB    = 7;
  localparam int unsigned TYPE_LSB    = 4;
  localparam int unsigned CSEL_MSB    = 3;
  localparam int unsigned CSEL_LSB    = 1;
  localparam int unsigned RW_BIT      = 0;
  // arbitrary neutral device-type code
  localparam logic [3:0]  DEV_TYPE    = 4'hB;

  // ------------------------------------------------------------
  // sizes and counter limits
  // ------------------------------------------------------------
  localparam int unsigned PAGE_BYTES  = 32;
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned TMR_W       = 17;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  localparam logic [1:0]  BYTE_DATA   = 2'h3;

  typedef enum logic [2:0] {
    ESC_IDLE,
    ESC_RX,
    ESC_ACK,
    ESC_TX,
    ESC_RACK
  } esc_state_t;

  // one array program write, streamed after stop
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } esc_prog_t;

  typedef struct packed {
    logic                       scl_s1;
    logic                       scl_s2;
    logic                       scl_p;
    logic                       sda_s1;
    logic                       sda_s2;
    logic                       sda_p;
    logic                       wp_s1;
    logic                       wp_s2;
    esc_state_t                 state;
    logic [3:0]                 bitcnt;
    logic [1:0]                 bcnt;
    logic [7:0]                 shift;
    logic                       wr;
    logic                       tx_next;
    logic                       drv;
    logic [ADDR_W-1:0]          ptr;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
    logic [PAGE_BYTES-1:0]      mask;
    logic [ADDR_W-1:5]          page;
    logic                       busy;
    logic [TMR_W-1:0]           tmr;
    logic                       rd_req;
    esc_prog_t                  prog;
  } esc_regs_t;

endpackage : esc_pkg

// ===== hw/esc_client.sv
// two-wire serial memory client front end: start/stop, control byte,
// word address, page buffer, acknowledge and read handshake
// assumes scl/sda/wp are asynchronous pins and straps static levels; the array and its
// read data live outside on core_clk_i
//
// Overview of operation
// - start (sda fall, scl high) restarts decoding
// - stop (sda rise, scl high) ends operation
// - sda changes only while scl low
// - receiver acknowledges on ninth clock pulse
// - acknowledge holds sda low through clock high
// - no acknowledge while programming cycle runs
// - host nack ends read; device releases sda
// - first byte: type, chip select, rw
// - chip select must match strap inputs
// - rw one reads, zero writes
// - acknowledge control byte only on full match
// - two address bytes, high first, 12 bits
// - page buffer keeps last 32 bytes
// - write protect blocks writes, not reads
// - stop after write launches timed cycle
// - write cycle ends within 5 ms
`timescale 1ns/10ps
module esc_client #(
  parameter int unsigned WC_CYCLES = esc_pkg::WC_CYCLES
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       scl_i,
  input  wire logic                       sda_i,
  output      logic                       sda_o,
  output      logic                       sda_oe_n_o,
  input  wire logic                       chip_sel_strap_0_i,
  input  wire logic                       chip_sel_strap_1_i,
  input  wire logic                       chip_sel_strap_2_i,
  input  wire logic                       wp_i,
  output      logic                       rd_req_o,
  output      logic [esc_pkg::ADDR_W-1:0] rd_addr_o,
  input  wire logic [7:0]                 rd_data_i,
  output      esc_pkg::esc_prog_t         prog_o,
  output      logic                       busy_o
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  // the timer must outlast the 32-cycle program stream and fit its width
  if (WC_CYCLES <= esc_pkg::PAGE_BYTES || WC_CYCLES >= (1 << esc_pkg::TMR_W)) begin : g_chk
    $error("esc_client: WC_CYCLES out of range");
  end

  localparam logic [esc_pkg::TMR_W-1:0] WC_LAST = esc_pkg::TMR_W'(WC_CYCLES - 1);

  esc_pkg::esc_regs_t q;
  esc_pkg::esc_regs_t d;

  logic       scl_hi;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic [2:0] straps;
  logic       match;

  // ------------------------------------------------------------
  // pin sampling and edge detection
  // ------------------------------------------------------------
  always_comb begin
    scl_hi   = q.scl_s2 & q.scl_p;
    scl_rise = q.scl_s2 & ~q.scl_p;
    scl_fall = ~q.scl_s2 & q.scl_p;
    // data edge inside a settled clock-high phase
    start_ev = scl_hi & q.sda_p & ~q.sda_s2;
    stop_ev  = scl_hi & ~q.sda_p & q.sda_s2;
    straps   = {chip_sel_strap_2_i, chip_sel_strap_1_i, chip_sel_strap_0_i};
    match    = (q.shift[esc_pkg::TYPE_MSB:esc_pkg::TYPE_LSB] == esc_pkg::DEV_TYPE)
             & (q.shift[esc_pkg::CSEL_MSB:esc_pkg::CSEL_LSB] == straps)
             & ~q.busy;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    // straps are static levels; only the bus pins and wp are synced
    d.scl_s1 = scl_i;
    d.scl_s2 = q.scl_s1;
    d.scl_p  = q.scl_s2;
    d.sda_s1 = sda_i;
    d.sda_s2 = q.sda_s1;
    d.sda_p  = q.sda_s2;
    d.wp_s1  = wp_i;
    d.wp_s2  = q.wp_s1;
    d.rd_req = 1'b0;
    d.prog   = '0;

    // self-timed program cycle; buffered bytes stream out first
    if (q.busy) begin
      if (q.tmr < esc_pkg::TMR_W'(esc_pkg::PAGE_BYTES)) begin
        d.prog.valid = q.mask[q.tmr[4:0]];
        d.prog.addr  = {q.page, q.tmr[4:0]};
        d.prog.data  = q.pbuf[q.tmr[4:0]];
      end
      d.tmr = q.tmr + 1'b1;
      if (q.tmr == WC_LAST) begin
        d.busy = 1'b0;
        d.mask = '0;
      end
    end

    if (start_ev) begin
      d.state  = esc_pkg::ESC_RX;
      d.bitcnt = '0;
      d.bcnt   = '0;
      d.wr     = 1'b0;
      d.drv    = 1'b0;
    end else if (stop_ev) begin
      d.state = esc_pkg::ESC_IDLE;
      d.drv   = 1'b0;
      d.wr    = 1'b0;
      // wp is taken at the stop; a protected write simply never starts
      if (q.wr && (|q.mask) && !q.busy && !q.wp_s2) begin
        d.busy = 1'b1;
        d.tmr  = '0;
      end
    end else begin
      case (q.state)
        esc_pkg::ESC_RX: begin
          if (scl_rise) begin
            d.shift  = {q.shift[6:0], q.sda_s2};
            d.bitcnt = q.bitcnt + 1'b1;
          end else if (scl_fall && q.bitcnt == esc_pkg::BITS_BYTE) begin
            // eighth bit done; sda may now be turned for the ack slot
            d.bitcnt  = '0;
            d.state   = esc_pkg::ESC_ACK;
            d.drv     = 1'b1;
            d.tx_next = 1'b0;
            if (q.bcnt != esc_pkg::BYTE_DATA) begin
              d.bcnt = q.bcnt + 1'b1;
            end
            case (q.bcnt)
              2'h0: begin
                if (match) begin
                  d.wr      = ~q.shift[esc_pkg::RW_BIT];
                  d.tx_next = q.shift[esc_pkg::RW_BIT];
                  d.rd_req  = q.shift[esc_pkg::RW_BIT];
                  if (!q.shift[esc_pkg::RW_BIT]) begin
                    d.mask = '0;
                  end
                end else begin
                  d.state = esc_pkg::ESC_IDLE;
                  d.drv   = 1'b0;
                end
              end
              2'h1: begin
                // upper four address bits are don't care
                d.ptr[11:8] = q.shift[3:0];
              end
              2'h2: begin
                d.ptr[7:0] = q.shift;
                d.page     = q.ptr[11:5];
              end
              default: begin
                // ring of 32: byte 33 lands on the oldest slot
                d.pbuf[q.ptr[4:0]] = q.shift;
                d.mask[q.ptr[4:0]] = 1'b1;
                d.ptr[4:0]         = q.ptr[4:0] + 1'b1;
                d.page             = q.ptr[11:5];
              end
            endcase
          end
        end
        esc_pkg::ESC_ACK: begin
          // low held from one falling edge to the next covers clock high
          if (scl_fall) begin
            d.drv = 1'b0;
            if (q.tx_next) begin
              d.shift  = {rd_data_i[6:0], 1'b0};
              d.drv    = ~rd_data_i[7];
              d.bitcnt = 4'h1;
              d.ptr    = q.ptr + 1'b1;
              d.state  = esc_pkg::ESC_TX;
            end else begin
              d.state = esc_pkg::ESC_RX;
            end
          end
        end
        esc_pkg::ESC_TX: begin
          if (scl_fall) begin
            if (q.bitcnt == esc_pkg::BITS_BYTE) begin
              d.drv    = 1'b0;
              d.bitcnt = '0;
              d.state  = esc_pkg::ESC_RACK;
            end else begin
              d.drv    = ~q.shift[7];
              d.shift  = {q.shift[6:0], 1'b0};
              d.bitcnt = q.bitcnt + 1'b1;
            end
          end
        end
        esc_pkg::ESC_RACK: begin
          if (scl_rise) begin
            if (q.sda_s2) begin
              d.state = esc_pkg::ESC_IDLE;
            end else begin
              d.rd_req  = 1'b1;
              d.tx_next = 1'b1;
              d.state   = esc_pkg::ESC_ACK;
            end
          end
        end
        default: begin
          d.drv = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~q.drv;
  assign rd_req_o   = q.rd_req;
  assign rd_addr_o  = q.ptr;
  assign prog_o     = q.prog;
  assign busy_o     = q.busy;

endmodule : esc_client

// ===== test/esc_host.sv
// bus host model: drives scl and its share of sda, samples the wire
// assumes the wire level is the and of both open-drain parties
`timescale 1ns/10ps
module esc_host (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output      logic scl_o,
  output      logic sda_o
);
  // ------------------------------------------------------------
  // bit level, 8 core cycles per scl period
  // ------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : tick
  // data moves mid-low, sampled mid-high, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    scl_o = 1'b0;
    tick(2);
    sda_o = b;
    tick(2);
    scl_o = 1'b1;
    tick(2);
    r = sda_i;
    tick(2);
  endtask : bit_io
  task automatic start();
    scl_o = 1'b0;
    tick(4);
    sda_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b0;
    tick(4);
  endtask : start
  task automatic stop();
    scl_o = 1'b0;
    tick(4);
    sda_o = 1'b0;
    tick(2);
    scl_o = 1'b1;
    tick(4);
    sda_o = 1'b1;
    tick(4);
  endtask : stop
  // ------------------------------------------------------------
  // byte level
  // ------------------------------------------------------------
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask : rd_byte
endmodule : esc_host

// ===== test/esc_client_sva.sv
// checker of bus-side timing of the memory client front end
// assumes it is bound to esc_client and sees only its ports
`timescale 1ns/10ps
module esc_client_sva #(
  parameter int unsigned WC_CYCLES = 200
) (
  input wire logic                       core_clk_i,
  input wire logic                       rstn_i,
  input wire logic                       scl_i,
  input wire logic                       sda_i,
  input wire logic                       sda_o,
  input wire logic                       sda_oe_n_o,
  input wire logic                       wp_i,
  input wire logic                       rd_req_o,
  input wire logic [esc_pkg::ADDR_W-1:0] rd_addr_o,
  input wire esc_pkg::esc_prog_t         prog_o,
  input wire logic                       busy_o
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  int unsigned busy_len_q;
  always_ff @(posedge core_clk_i) begin
    busy_len_q <= (!rstn_i || !busy_o) ? 0 : busy_len_q + 1;
  end
  sequence scl_held;
    scl_i ##1 scl_i;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sda_low_only_a: assert property (sda_o == 1'b0)
    else $error("sda data value not low");
  ack_stable_a: assert property (scl_held |-> $stable(sda_oe_n_o))
    else $error("sda drive changed while scl high");
  drive_on_low_a: assert property ($fell(sda_oe_n_o) |-> !scl_i)
    else $error("sda pulled low while scl high");
  busy_quiet_a: assert property (busy_o |-> sda_oe_n_o)
    else $error("sda driven during write cycle");
  req_pulse_a: assert property (rd_req_o |-> !busy_o ##1 !rd_req_o)
    else $error("read request not a single pulse");
  launch_stop_a: assert property ($rose(busy_o) |-> scl_i && sda_i && sda_oe_n_o)
    else $error("write cycle began without stop");
  wp_block_a: assert property ($rose(busy_o) |-> !wp_i && !$past(wp_i, 4))
    else $error("write cycle began while protected");
  wc_bound_a: assert property (busy_len_q <= WC_CYCLES)
    else $error("write cycle too long");
  prog_busy_a: assert property (prog_o.valid |-> busy_o)
    else $error("array write outside write cycle");
  page_keep_a: assert property (prog_o.valid |-> prog_o.addr[11:5] == rd_addr_o[11:5])
    else $error("array write left the page");
endmodule : esc_client_sva
bind esc_client esc_client_sva #(.WC_CYCLES(WC_CYCLES)) esc_client_sva_i (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i), .rd_req_o(rd_req_o),
  .rd_addr_o(rd_addr_o), .prog_o(prog_o), .busy_o(busy_o)
);

// ===== test/tb_top.sv
// testbench of the memory client front end, host model on the bus
// assumes a pull-up on sda and a read array of addr xor 5A
`timescale 1ns/10ps
module tb_top;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  logic                core_clk = 1'b0;
  logic                rstn     = 1'b0;
  logic                wp       = 1'b0;
  logic [2:0]          strap    = 3'h5;
  logic                scl;
  logic                sda_h;
  logic                sda_d;
  logic                sda_oe_n;
  logic                rd_req;
  logic                busy;
  logic [11:0]         rd_addr;
  logic [7:0]          rd_data;
  esc_pkg::esc_prog_t  prog;
  logic [11:0]         pcnt     = 12'h000;
  logic [6:0]          ppage;
  logic [31:0][7:0]    pmem;
  int                  err_count = 0;
  int                  tests_run = 0;
  int                  cyc       = 0;
  wire                 sda_w = sda_h & (sda_oe_n | sda_d);
  assign rd_data = rd_addr[7:0] ^ 8'h5A;
  always #20 core_clk = ~core_clk;
  esc_host esc_host_i (.core_clk_i(core_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h));
  esc_client #(.WC_CYCLES(200)) esc_client_i (
    .core_clk_i(core_clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d),
    .sda_oe_n_o(sda_oe_n), .chip_sel_strap_0_i(strap[0]), .chip_sel_strap_1_i(strap[1]),
    .chip_sel_strap_2_i(strap[2]), .wp_i(wp), .rd_req_o(rd_req), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .prog_o(prog), .busy_o(busy)
  );
  always @(posedge core_clk) begin
    if (prog.valid === 1'b1) begin
      pmem[prog.addr[4:0]] <= prog.data;
      ppage <= prog.addr[11:5];
      pcnt <= pcnt + 12'h001;
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk_val(input logic [11:0] g, input logic [11:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk_val
  task automatic wb(input logic [7:0] x, input logic e);
    logic a;
    esc_host_i.wr_byte(x, a);
    chk_val({11'h000, a}, {11'h000, e});
  endtask : wb
  function automatic logic [7:0] ctl(input logic [2:0] cs, input logic rw);
    return {esc_pkg::DEV_TYPE, cs, rw};
  endfunction : ctl
  // stalls end at 20000 cycles, far above the whole run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  d;
    logic [11:0] pbase;
    repeat (5) @(posedge core_clk);
    #1 rstn = 1'b1;
    esc_host_i.tick(6);
    chk_val({11'h000, sda_oe_n}, 12'h001);
    esc_host_i.start();
    wb(ctl(3'h5, 1'b0), 1'b1);
    wb(8'hF3, 1'b1);
    wb(8'hE0, 1'b1);
    for (int i = 0; i < 34; i++) wb(i[7:0], 1'b1);
    esc_host_i.stop();
    esc_host_i.tick(2);
    chk_val({11'h000, busy}, 12'h001);
    esc_host_i.start();
    wb(ctl(3'h5, 1'b0), 1'b0);
    esc_host_i.stop();
    for (int i = 0; i < 400 && busy !== 1'b0; i++) esc_host_i.tick(1);
    chk_val(pcnt, 12'h020);
    chk_val({5'h00, ppage}, 12'h01F);
    for (int k = 0; k < 32; k++) chk_val({4'h0, pmem[k]}, 12'(k < 2 ? k + 32 : k));
    $display("test page write done");
    esc_host_i.start();
    wb(ctl(3'h4, 1'b0), 1'b0);
    esc_host_i.start();
    wb(ctl(3'h5, 1'b0) ^ 8'h80, 1'b0);
    esc_host_i.start();
    wb(ctl(3'h5, 1'b0), 1'b1);
    wb(8'h01, 1'b1);
    wb(8'h40, 1'b1);
    esc_host_i.start();
    wb(ctl(3'h5, 1'b1), 1'b1);
    esc_host_i.rd_byte(1'b1, d);
    chk_val({4'h0, d}, 12'h01A);
    esc_host_i.rd_byte(1'b0, d);
    chk_val({4'h0, d}, 12'h01B);
    chk_val({11'h000, sda_oe_n}, 12'h001);
    esc_host_i.stop();
    chk_val({11'h000, busy}, 12'h000);
    $display("test select and read done");
    wp = 1'b1;
    pbase = pcnt;
    esc_host_i.start();
    wb(ctl(3'h5, 1'b0), 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'hAA, 1'b1);
    esc_host_i.stop();
    esc_host_i.tick(10);
    chk_val({11'h000, busy}, 12'h000);
    chk_val(pcnt - pbase, 12'h000);
    $display("test write protect done");
    end_sim();
  end
endmodule : tb_top
